/* hbr_pkg.sv */
package hbr_pkg;

   // Width of the host data and address buses
   localparam int unsigned HBR_DATA_W = 8;
   localparam int unsigned HBR_ADDR_W = 7;
   localparam int unsigned HBR_MODE_W = 2;

   // Width of the pin bundle that crosses into the clock domain
   localparam int unsigned HBR_PIN_W  = 3 + HBR_MODE_W + HBR_DATA_W + HBR_ADDR_W;

   // Field positions inside the pin bundle
   localparam int unsigned HBR_PIN_SEL   = 0;
   localparam int unsigned HBR_PIN_STRB  = 1;
   localparam int unsigned HBR_PIN_RW    = 2;
   localparam int unsigned HBR_PIN_MODE  = 3;
   localparam int unsigned HBR_PIN_DATA  = HBR_PIN_MODE + HBR_MODE_W;
   localparam int unsigned HBR_PIN_ADDR  = HBR_PIN_DATA + HBR_DATA_W;

   // Strap codes on the bus mode pins
   localparam logic [HBR_MODE_W-1:0] HBR_STRAP_RDWR  = 2'h0;
   localparam logic [HBR_MODE_W-1:0] HBR_STRAP_DSACK = 2'h1;
   localparam logic [HBR_MODE_W-1:0] HBR_STRAP_SYNC  = 2'h2;

   // Bus modes after strap decode
   typedef enum logic [1:0] {
      HBR_MODE_RDWR,
      HBR_MODE_DSACK,
      HBR_MODE_SYNC
   } hbr_mode_e;

   // Cycle handling states
   typedef enum logic [1:0] {
      HBR_ST_IDLE,
      HBR_ST_WAIT,
      HBR_ST_HOLD
   } hbr_state_e;

   // Complete state of the termination block
   typedef struct packed {
      hbr_state_e                state;
      hbr_mode_e                 mode;
      logic                      strap_taken;
      logic                      done_pin;
      logic                      req_valid;
      logic                      req_write;
      logic [HBR_ADDR_W-1:0]     req_addr;
      logic [HBR_DATA_W-1:0]     req_wdata;
   } hbr_top_s;

   // Reset value: pin high, which is inactive for both strobe modes
   localparam hbr_top_s HBR_TOP_RESET = '{
      state       : HBR_ST_IDLE,
      mode        : HBR_MODE_RDWR,
      strap_taken : 1'b0,
      done_pin    : 1'b1,
      req_valid   : 1'b0,
      req_write   : 1'b0,
      req_addr    : 7'h00,
      req_wdata   : 8'h00
   };

   // Two-stage synchroniser state
   typedef struct packed {
      logic [HBR_PIN_W-1:0]      stage1;
      logic [HBR_PIN_W-1:0]      stage2;
   } hbr_sync_s;

endpackage

/* hbr_pin_if.sv */
`timescale 1ns/1ps
interface hbr_pin_if;
   import hbr_pkg::*;

   logic [HBR_PIN_W-1:0]   raw;     // Pin bundle straight from the pads
   logic [HBR_PIN_W-1:0]   synced;  // Same bundle after two flip-flops

   modport sync_side (input raw, output synced);
   modport user_side (output raw, input synced);
endinterface

/* hbr_sync2.sv */
`timescale 1ns/1ps
module hbr_sync2
   import hbr_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       clk_en_i,
   hbr_pin_if.sync_side    pins
);

   hbr_sync_s st;       // Registered stages
   hbr_sync_s next_st;  // Next value of the stages

   // First stage feeds only the second; nothing else looks at it
   always_comb
   begin
      next_st        = st;
      next_st.stage1 = pins.raw;
      next_st.stage2 = st.stage1;
   end

   // Frozen while the clock enable is low, but kept filling during reset
   // No reset value: a constant here would read as a selected cycle and a
   // wrong strap on the first edges after release; live pin levels avoid it
   // Limitation: reset must span at least two clock edges
   always_ff @(posedge clk_i)
   begin
      if (clk_en_i || !rst_n_i)
      begin
         st <= next_st;
      end
   end

   assign pins.synced = st.stage2;

endmodule

/* hbr_top.sv */
// Behaviour
// R01: Strobe mode: output is active-low ready
// R02: Async modes: drive low only when completing
// R03: Host stretches cycle while output stays high
// R04: Acknowledge mode: output is active-low transfer acknowledge
// R05: Sync mode: active-high ready, low before completion
// R06: Host samples ready on rising clock edges
// R07: Output changes only on rising clock edge; the asynchronous reset also drives it high at any time
// R08: Sync write captures data on sampling edge
// R09: Host asserts chip select for every access
// R10: Outside cycles, output sits at inactive level; sync mode pin is high until first enabled edge after reset
`timescale 1ns/1ps
module hbr_top
   import hbr_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  clk_en_i,
   input  wire logic [HBR_MODE_W-1:0] mode_strap_i,
   input  wire logic                  host_select_n_i,
   input  wire logic                  strobe_n_i,
   input  wire logic                  rw_i,
   input  wire logic [HBR_DATA_W-1:0] host_data_i,
   input  wire logic [HBR_ADDR_W-1:0] host_addr_i,
   input  wire logic                  core_ack_i,
   output logic                       cycle_done_out_o,
   output logic                       req_valid_o,
   output logic                       req_write_o,
   output logic [HBR_ADDR_W-1:0]      req_addr_o,
   output logic [HBR_DATA_W-1:0]      req_wdata_o
);

   hbr_top_s st;       // Registered state of the block
   hbr_top_s next_st;  // Next value of the state

   hbr_pin_if pins ();  // Pin bundle on its way into the clock domain

   // Synchronised view of the pins, used by the asynchronous modes
   logic                  s_sel_n;   // Chip select after synchroniser
   logic                  s_strb_n;  // Strobe after synchroniser
   logic                  s_rw;      // Direction line after synchroniser
   logic [HBR_MODE_W-1:0] s_mode;    // Mode strap after synchroniser
   logic [HBR_DATA_W-1:0] s_data;    // Data bus after synchroniser
   logic [HBR_ADDR_W-1:0] s_addr;    // Address bus after synchroniser

   // Cycle decode results, per mode
   logic                  cyc_active;  // A selected cycle is present
   logic                  cyc_write;   // That cycle is a write
   logic [HBR_DATA_W-1:0] cyc_data;    // Data seen for that cycle
   logic [HBR_ADDR_W-1:0] cyc_addr;    // Address seen for that cycle
   logic                  is_sync;     // Clocked bus mode selected

   // Pack the pins into one bundle for the synchroniser
   assign pins.raw[HBR_PIN_SEL]                          = host_select_n_i;
   assign pins.raw[HBR_PIN_STRB]                         = strobe_n_i;
   assign pins.raw[HBR_PIN_RW]                           = rw_i;
   assign pins.raw[HBR_PIN_MODE +: HBR_MODE_W]           = mode_strap_i;
   assign pins.raw[HBR_PIN_DATA +: HBR_DATA_W]           = host_data_i;
   assign pins.raw[HBR_PIN_ADDR +: HBR_ADDR_W]           = host_addr_i;

   // Two flip-flops on every pin before the asynchronous logic reads it
   hbr_sync2 u_sync (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .clk_en_i (clk_en_i),
      .pins     (pins)
   );

   // Unpack the synchronised bundle
   assign s_sel_n  = pins.synced[HBR_PIN_SEL];
   assign s_strb_n = pins.synced[HBR_PIN_STRB];
   assign s_rw     = pins.synced[HBR_PIN_RW];
   assign s_mode   = pins.synced[HBR_PIN_MODE +: HBR_MODE_W];
   assign s_data   = pins.synced[HBR_PIN_DATA +: HBR_DATA_W];
   assign s_addr   = pins.synced[HBR_PIN_ADDR +: HBR_ADDR_W];

   assign is_sync = (st.mode == HBR_MODE_SYNC);

   // Cycle decode for the configured mode
   // The clocked mode reads the raw pins: the host runs on this clock,
   // and a write must land on the very edge it is sampled on.
   // The strobe modes read the synchronised pins; data and address are
   // held stable by the host for the whole strobe, so the multi-bit
   // bundle has settled by the time the synchronised strobe arrives.
   always_comb
   begin
      cyc_active = 1'b0;
      cyc_write  = 1'b0;
      cyc_data   = s_data;
      cyc_addr   = s_addr;
      case (st.mode)
         HBR_MODE_RDWR:
         begin
            // Strobe pin carries the read strobe; rw_i low is write strobe
            cyc_active = !s_sel_n && (!s_strb_n || !s_rw);
            cyc_write  = !s_rw;
         end
         HBR_MODE_DSACK:
         begin
            // Data strobe frames the cycle; rw_i high reads, low writes
            cyc_active = !s_sel_n && !s_strb_n;
            cyc_write  = !s_rw;
         end
         HBR_MODE_SYNC:
         begin
            // Write: select, write enable and direction all low
            // Read: select low with direction high
            cyc_active = !host_select_n_i && (rw_i || !strobe_n_i);
            cyc_write  = !rw_i && !strobe_n_i;
            cyc_data   = host_data_i;
            cyc_addr   = host_addr_i;
         end
         default:
         begin
            cyc_active = 1'b0;
            cyc_write  = 1'b0;
         end
      endcase
   end

   // Next-state logic of the cycle handler
   always_comb
   begin
      next_st           = st;
      next_st.req_valid = 1'b0;
      case (st.state)
         HBR_ST_IDLE:
         begin
            if (!st.strap_taken)
            begin
               // Strap is caught once, on the first enabled edge after reset
               next_st.strap_taken = 1'b1;
               case (s_mode)
                  HBR_STRAP_DSACK: next_st.mode = HBR_MODE_DSACK;
                  HBR_STRAP_SYNC:  next_st.mode = HBR_MODE_SYNC;
                  default:         next_st.mode = HBR_MODE_RDWR;
               endcase
               // Park the pin at the inactive level of the new mode
               next_st.done_pin = (s_mode == HBR_STRAP_SYNC) ? 1'b0 : 1'b1; // R10
            end
            else if (cyc_active)
            begin
               // Hand the access to the core; capture on this same edge
               next_st.req_valid = 1'b1;
               next_st.req_write = cyc_write;
               next_st.req_addr  = cyc_addr;
               if (cyc_write)
               begin
                  next_st.req_wdata = cyc_data; // R08
               end
               next_st.state = HBR_ST_WAIT;
            end
            else
            begin
               // No cycle: termination sits inactive
               next_st.done_pin = is_sync ? 1'b0 : 1'b1; // R10
            end
         end
         HBR_ST_WAIT:
         begin
            if (!cyc_active && !is_sync)
            begin
               // Host gave up the strobe early; drop back without acknowledging
               next_st.done_pin = 1'b1; // R10
               next_st.state    = HBR_ST_IDLE;
            end
            else if (core_ack_i)
            begin
               // Core can finish the cycle: assert termination now
               next_st.done_pin = is_sync ? 1'b1 : 1'b0; // R01 R04 R05
               next_st.state    = HBR_ST_HOLD;
            end
            else
            begin
               // Not ready yet: keep termination inactive, host stretches
               next_st.done_pin = is_sync ? 1'b0 : 1'b1; // R02 R05
            end
         end
         HBR_ST_HOLD:
         begin
            if (is_sync)
            begin
               // Ready stands for one clock, the edge the host samples it on
               next_st.done_pin = 1'b0; // R05
               next_st.state    = HBR_ST_IDLE;
            end
            else if (!cyc_active)
            begin
               // Strobe released: release the termination and rearm
               next_st.done_pin = 1'b1; // R02 R10
               next_st.state    = HBR_ST_IDLE;
            end
            else
            begin
               // Hold low until the host ends the strobe, so it cannot miss it
               next_st.done_pin = 1'b0; // R02
            end
         end
         default:
         begin
            next_st.state    = HBR_ST_IDLE;
            next_st.done_pin = is_sync ? 1'b0 : 1'b1;
         end
      endcase
   end

   // All state, including the pin, moves only on the rising edge, apart from the asynchronous reset
   always_ff @(posedge clk_i or negedge rst_n_i) // R07
   begin
      if (!rst_n_i)
      begin
         st <= HBR_TOP_RESET;
      end
      else if (clk_en_i)
      begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state flip-flops
   assign cycle_done_out_o = st.done_pin;
   assign req_valid_o      = st.req_valid;
   assign req_write_o      = st.req_write;
   assign req_addr_o       = st.req_addr;
   assign req_wdata_o      = st.req_wdata;

endmodule

/* hbr_top_asserts.sv */
`timescale 1ns/1ps
module hbr_top_asserts
   import hbr_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  clk_en_i,
   input  wire logic [HBR_MODE_W-1:0] mode_strap_i,
   input  wire logic                  host_select_n_i,
   input  wire logic                  strobe_n_i,
   input  wire logic                  rw_i,
   input  wire logic [HBR_DATA_W-1:0] host_data_i,
   input  wire logic [HBR_ADDR_W-1:0] host_addr_i,
   input  wire logic                  core_ack_i,
   input  wire logic                  cycle_done_out_o,
   input  wire logic                  req_valid_o,
   input  wire logic                  req_write_o,
   input  wire logic [HBR_ADDR_W-1:0] req_addr_o,
   input  wire logic [HBR_DATA_W-1:0] req_wdata_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic sy;      // Clocked mode strapped
   logic pin_neg; // Pin as seen at the falling edge
   assign sy = (mode_strap_i == HBR_STRAP_SYNC);
   // Mid-cycle copy; a change between edges shows as a mismatch
   always_ff @(negedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pin_neg <= 1'b1;
      else
         pin_neg <= cycle_done_out_o;
   end
   // Quiet host; lengths cover the two-stage synchroniser lag
   sequence s_async_quiet;
      (!sy && host_select_n_i) [*4];
   endsequence
   sequence s_sync_quiet;
      (sy && host_select_n_i) [*3];
   endsequence
   sequence s_sync_write;
      sy && $rose(req_valid_o) && req_write_o;
   endsequence
   AST_ASYNC_FALL_ON_ACK: assert property (!sy && $fell(cycle_done_out_o) |-> $past(core_ack_i))
      else $error("strobe mode pin fell without core ack");
   AST_ASYNC_HOLD_LOW: assert property (!sy && $fell(cycle_done_out_o) |=> !cycle_done_out_o)
      else $error("strobe mode pin low for one cycle only");
   AST_ASYNC_IDLE_HIGH: assert property (s_async_quiet |-> cycle_done_out_o)
      else $error("strobe mode pin low while deselected");
   AST_SYNC_RISE_ON_ACK: assert property (sy && $rose(cycle_done_out_o) |-> $past(core_ack_i))
      else $error("clocked mode ready rose without core ack");
   AST_SYNC_ONE_CYCLE: assert property (sy && $rose(cycle_done_out_o) |=> !cycle_done_out_o)
      else $error("clocked mode ready longer than one cycle");
   AST_SYNC_IDLE_LOW: assert property (s_sync_quiet |-> !cycle_done_out_o)
      else $error("clocked mode ready high while deselected");
   AST_SYNC_CAPTURE: assert property (s_sync_write |-> req_wdata_o == $past(host_data_i))
      else $error("clocked write data not taken on its edge");
   AST_EDGE_ONLY: assert property (cycle_done_out_o == pin_neg)
      else $error("pin changed away from rising edge");
endmodule
bind hbr_top hbr_top_asserts i_hbr_top_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
   .mode_strap_i(mode_strap_i), .host_select_n_i(host_select_n_i), .strobe_n_i(strobe_n_i), .rw_i(rw_i),
   .host_data_i(host_data_i), .host_addr_i(host_addr_i), .core_ack_i(core_ack_i),
   .cycle_done_out_o(cycle_done_out_o), .req_valid_o(req_valid_o), .req_write_o(req_write_o),
   .req_addr_o(req_addr_o), .req_wdata_o(req_wdata_o));

/* hbr_host_model.sv */
`timescale 1ns/1ps
module hbr_host_model
   import hbr_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic [HBR_MODE_W-1:0] mode_i,
   input  wire logic                  start_i,
   input  wire logic                  write_i,
   input  wire logic                  abort_i,
   input  wire logic [HBR_ADDR_W-1:0] addr_i,
   input  wire logic [HBR_DATA_W-1:0] data_i,
   input  wire logic                  done_pin_i,
   output logic                       sel_n_o,
   output logic                       strobe_n_o,
   output logic                       rw_o,
   output logic [HBR_ADDR_W-1:0]      addr_o,
   output logic [HBR_DATA_W-1:0]      data_o,
   output logic                       busy_o
);
   logic [1:0] phase = 2'h0;        // Idle, cycle open, waiting for rearm
   logic       seen, go, stop, wr;  // Inputs taken at the edge
   assign busy_o = (phase != 2'h0);
   // Inverted buses so a stale value never looks valid
   task automatic release_bus();
      sel_n_o = 1'b1;
      strobe_n_o = 1'b1;
      rw_o = 1'b1;
      addr_o = ~addr_o;
      data_o = ~data_o;
   endtask
   initial
   begin
      addr_o = 7'h00;
      data_o = 8'h00;
      release_bus();
   end
   // Sample on the edge, move just after it
   always @(posedge clk_i)
   begin
      seen = (mode_i == HBR_STRAP_SYNC) ? done_pin_i : !done_pin_i;
      go = start_i;
      stop = abort_i;
      wr = write_i;
      #1;
      if (!rst_n_i)
      begin
         phase = 2'h0;
         release_bus();
      end
      else if (phase == 2'h0 && go)
      begin
         sel_n_o = 1'b0;
         addr_o = addr_i;
         data_o = data_i;
         rw_o = !wr;
         if (mode_i == HBR_STRAP_SYNC)
            strobe_n_o = !wr;
         else
            strobe_n_o = (mode_i == HBR_STRAP_DSACK) ? 1'b0 : wr;
         phase = 2'h1;
      end
      else if (phase == 2'h1 && (seen || stop))
      begin
         release_bus();
         phase = (mode_i == HBR_STRAP_SYNC) ? 2'h0 : 2'h2;
      end
      else if (phase == 2'h2 && !seen)
         phase = 2'h0;
   end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import hbr_pkg::*;
;
   `define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; \
      $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
   logic                  clk_i;
   logic                  rst_n_i = 1'b0;
   logic [HBR_MODE_W-1:0] strap = 2'h0;
   logic                  ack = 1'b0, start = 1'b0, wr = 1'b0, abort = 1'b0, act = 1'b0, en = 1'b1;
   logic [HBR_ADDR_W-1:0] a_cmd = 7'h00, h_addr, raddr;
   logic [HBR_DATA_W-1:0] d_cmd = 8'h00, h_data, rdata;
   logic                  sel_n, stb_n, rw, pin, rv, rwr, busy;
   int                    fails = 0, checks = 0, cyc = 0;
   hbr_top i_hbr_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(en), .mode_strap_i(strap),
      .host_select_n_i(sel_n), .strobe_n_i(stb_n), .rw_i(rw), .host_data_i(h_data), .host_addr_i(h_addr),
      .core_ack_i(ack), .cycle_done_out_o(pin), .req_valid_o(rv), .req_write_o(rwr), .req_addr_o(raddr),
      .req_wdata_o(rdata));
   hbr_host_model i_hbr_host_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(strap), .start_i(start),
      .write_i(wr), .abort_i(abort), .addr_i(a_cmd), .data_i(d_cmd), .done_pin_i(pin), .sel_n_o(sel_n),
      .strobe_n_o(stb_n), .rw_o(rw), .addr_o(h_addr), .data_o(h_data), .busy_o(busy));
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         fails++;
         print_verdict();
      end
   end
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask
   task automatic do_reset(input logic [HBR_MODE_W-1:0] s);
      rst_n_i = 1'b0;
      strap = s;
      act = (s == HBR_STRAP_SYNC);
      repeat (4) tick();
      rst_n_i = 1'b1;
      repeat (3) tick();
      `CHK("pin after reset", ~act, pin)
   endtask
   task automatic go(input logic w, input logic [HBR_ADDR_W-1:0] a, input logic [HBR_DATA_W-1:0] d);
      tick();
      wr = w;
      a_cmd = a;
      d_cmd = d;
      start = 1'b1;
      tick();
      start = 1'b0;
   endtask
   // One host access; core holds off for hold cycles
   task automatic access(input logic w, input logic [HBR_ADDR_W-1:0] a, input logic [HBR_DATA_W-1:0] d,
                         input int hold);
      int n;
      go(w, a, d);
      for (n = 0; n < 20 && rv !== 1'b1; n++) tick();
      `CHK("req_valid", 1'b1, rv)
      `CHK("req_write", w, rwr)
      `CHK("req_addr", a, raddr)
      if (w) `CHK("req_wdata", d, rdata)
      repeat (hold)
      begin
         tick();
         `CHK("pin waiting", ~act, pin)
      end
      ack = 1'b1;
      for (n = 0; n < 20 && pin !== act; n++) tick();
      `CHK("pin done", act, pin)
      ack = 1'b0;
      tick();
      if (act) `CHK("ready one cycle", 1'b0, pin)
      for (n = 0; n < 20 && busy !== 1'b0; n++) tick();
      repeat (4) tick();
      `CHK("pin idle", ~act, pin)
   endtask
   task automatic test_strobe();
      do_reset(2'h0);
      access(1'b0, 7'h55, 8'h00, 3);
      access(1'b1, 7'h2a, 8'ha5, 0);
      do_reset(2'h3);
      access(1'b0, 7'h7f, 8'h00, 0);
      $display("test strobe mode done");
   endtask
   task automatic test_ack();
      do_reset(2'h1);
      access(1'b0, 7'h01, 8'h00, 2);
      access(1'b1, 7'h40, 8'h5a, 0);
      $display("test ack mode done");
   endtask
   task automatic test_clocked();
      do_reset(2'h2);
      access(1'b1, 7'h3c, 8'hc3, 0);
      access(1'b0, 7'h12, 8'h00, 4);
      access(1'b1, 7'h00, 8'hff, 1);
      $display("test clocked mode done");
   endtask
   // Enable low mid-cycle: ready must wait for the enable to return
   task automatic test_freeze();
      int n;
      do_reset(2'h2);
      go(1'b1, 7'h33, 8'h3c);
      for (n = 0; n < 20 && rv !== 1'b1; n++) tick();
      `CHK("req_valid", 1'b1, rv)
      `CHK("req_wdata", 8'h3c, rdata)
      en = 1'b0;
      ack = 1'b1;
      repeat (3)
      begin
         tick();
         `CHK("pin frozen", 1'b0, pin)
      end
      en = 1'b1;
      tick();
      `CHK("pin after enable", 1'b1, pin)
      ack = 1'b0;
      tick();
      `CHK("ready one cycle", 1'b0, pin)
      for (n = 0; n < 20 && busy !== 1'b0; n++) tick();
      $display("test freeze done");
   endtask
   // Host gives up early; pin must never signal completion
   task automatic test_abort();
      int n;
      do_reset(2'h0);
      go(1'b0, 7'h11, 8'h00);
      for (n = 0; n < 20 && rv !== 1'b1; n++) tick();
      abort = 1'b1;
      tick();
      abort = 1'b0;
      for (n = 0; n < 10; n++)
      begin
         tick();
         ack = (n > 4);
         `CHK("pin after abort", 1'b1, pin)
      end
      ack = 1'b0;
      $display("test abort done");
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      test_strobe();
      test_ack();
      test_clocked();
      test_freeze();
      test_abort();
      print_verdict();
   end
endmodule
